// *** src/pta_pkg.sv ***
// Purpose: shared constants and carriers for the eight-pin port block
// Assumes: 8-bit register port, byte-wide pins
// Notes: register indices are the word addresses on the plain register port
`default_nettype none
package pta_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] ADDR_LEVEL = 4'h0;
  localparam logic [3:0] ADDR_LATCH = 4'h1;
  localparam logic [3:0] ADDR_DIR = 4'h2;
  localparam logic [3:0] ADDR_ANSEL = 4'h3;
  localparam logic [3:0] ADDR_SLEW = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h5;

  localparam logic [7:0] DIR_RESET = 8'hFF;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] ANSEL_RESET = 8'h2F;
  localparam logic [7:0] ANSEL_MASK = 8'h2F;
  localparam logic [7:0] SLEW_RESET = 8'h01;
  localparam logic [7:0] SLEW_MASK = 8'h01;
  localparam logic [7:0] OSC_PIN_MASK = 8'hC0;

  localparam int unsigned PIN_DAC = 2;
  localparam int unsigned PIN_SRQ = 4;
  localparam int unsigned PIN_C2 = 5;
  localparam int unsigned PIN_CLOCK_OUT_FUNCTION = 6;
  localparam int unsigned PIN_OSC_IN = 7;

  localparam int unsigned CLOCK_OUT_FUNCTION_DIV = 4;

  // oscillator configuration seen by the port
  typedef struct packed {
    logic int_osc;
    logic clock_out_function_en;
    logic rc_mode;
  } pta_osc_cfg_t;

  // peripheral output requests sharing the pins
  typedef struct packed {
    logic dac_en;
    logic srq_en;
    logic srq_val;
    logic sr_latch_inverted_output_en;
    logic sr_latch_inverted_output_val;
    logic c1_oe;
    logic c1_val;
    logic c2_oe;
    logic c2_val;
  } pta_periph_t;
endpackage : pta_pkg
`default_nettype wire

// *** src/pta_port.sv ***
// Purpose: eight-pin bidirectional general-purpose port with shared functions
// Assumes: one clock, synchronous active-high reset, pins as in/out/enable
// Notes: reads have no side effects; read data valid the cycle after a read strobe
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`default_nettype none
module pta_port #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic [pta_pkg::ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire pta_pkg::pta_osc_cfg_t i_osc_cfg,
  input wire pta_pkg::pta_periph_t i_periph,
  input wire logic i_osc_in_clk,
  input wire logic [WIDTH-1:0] i_pin,
  output logic [WIDTH-1:0] o_pin,
  output logic [WIDTH-1:0] o_pin_oe,
  output logic o_timer_zero_ext_clock_in,
  output logic [WIDTH-1:0] o_slew_limit
);
  if (WIDTH != 8)
  begin : g_width_check
    $error("pta_port supports exactly 8 pins");
  end

  logic [7:0] latch_q;
  logic [7:0] dir_q;
  logic [7:0] ansel_q;
  logic [7:0] slew_q;
  logic [7:0] sync1_q;
  logic [7:0] sync2_q;
  logic [7:0] rdata_q;
  logic [1:0] div_q;
  logic clock_out_function_q;
  logic osc_owns_hi;
  logic pin6_port;
  logic [7:0] own_mask;
  logic [7:0] dig_in_en;
  logic [7:0] level_view;
  logic [7:0] drv_val;
  logic [7:0] drv_oe;
  logic [7:0] rd_d;
  logic wr_lat;

  // pin 7 is port only in internal oscillator modes; pin 6 also needs clock out off
  assign osc_owns_hi = ~i_osc_cfg.int_osc;
  assign pin6_port = i_osc_cfg.int_osc & ~i_osc_cfg.clock_out_function_en;
  assign own_mask = {~osc_owns_hi, pin6_port, 6'h3F};

  // latch writes come from either the level or the latch address
  assign wr_lat = i_wr & ((i_addr == pta_pkg::ADDR_LEVEL) | (i_addr == pta_pkg::ADDR_LATCH));

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      latch_q <= pta_pkg::LATCH_RESET;
    else if (wr_lat)
      latch_q <= i_wdata;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      dir_q <= pta_pkg::DIR_RESET;
    else if (i_wr && i_addr == pta_pkg::ADDR_DIR)
      dir_q <= i_wdata;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      ansel_q <= pta_pkg::ANSEL_RESET;
    else if (i_wr && i_addr == pta_pkg::ADDR_ANSEL)
      ansel_q <= i_wdata & pta_pkg::ANSEL_MASK;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      slew_q <= pta_pkg::SLEW_RESET;
    else if (i_wr && i_addr == pta_pkg::ADDR_SLEW)
      slew_q <= i_wdata & pta_pkg::SLEW_MASK;
  end

  assign o_slew_limit = {WIDTH{slew_q[0]}};

  // first stage is read only by the second stage
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
    end
    else
    begin
      sync1_q <= i_pin;
      sync2_q <= sync1_q;
    end
  end

  // quarter-rate clock out, counted on rising edges of the oscillator input level
  logic osc_in_q;
  logic osc_rise;
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      osc_in_q <= 1'b0;
    else
      osc_in_q <= i_osc_in_clk;
  end
  assign osc_rise = i_osc_in_clk & ~osc_in_q;

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      div_q <= 2'h0;
      clock_out_function_q <= 1'b0;
    end
    else if (osc_rise)
    begin
      div_q <= div_q + 2'h1;
      if (div_q == 2'(pta_pkg::CLOCK_OUT_FUNCTION_DIV / 2 - 1) || div_q == 2'(pta_pkg::CLOCK_OUT_FUNCTION_DIV - 1))
        clock_out_function_q <= ~clock_out_function_q;
    end
  end

  // digital input path: off for analog inputs, dac pin, oscillator pins
  always_comb
  begin
    dig_in_en = own_mask & ~(ansel_q & dir_q);
    if (i_periph.dac_en)
      dig_in_en[pta_pkg::PIN_DAC] = 1'b0;
    level_view = sync2_q & dig_in_en;
  end

  // output priority per pin, highest first
  always_comb
  begin
    drv_val = latch_q;
    drv_oe = ~dir_q & own_mask;
    if (i_periph.dac_en)
    begin
      drv_oe[pta_pkg::PIN_DAC] = 1'b0;
      drv_val[pta_pkg::PIN_DAC] = 1'b0;
    end
    // pin 4: sr latch beats comparator one beats port
    if (i_periph.srq_en)
    begin
      drv_val[pta_pkg::PIN_SRQ] = i_periph.srq_val;
      drv_oe[pta_pkg::PIN_SRQ] = 1'b1;
    end
    else if (i_periph.c1_oe)
    begin
      drv_val[pta_pkg::PIN_SRQ] = i_periph.c1_val;
      drv_oe[pta_pkg::PIN_SRQ] = ~dir_q[pta_pkg::PIN_SRQ];
    end
    // pin 5: inverted sr output beats comparator two; both need direction zero
    if (i_periph.sr_latch_inverted_output_en)
      drv_val[pta_pkg::PIN_C2] = i_periph.sr_latch_inverted_output_val;
    else if (i_periph.c2_oe)
      drv_val[pta_pkg::PIN_C2] = i_periph.c2_val;
    // pin 6: clock out in rc mode and when clock out is on with the internal oscillator; other external modes leave it undriven here
    if (osc_owns_hi)
    begin
      drv_val[pta_pkg::PIN_CLOCK_OUT_FUNCTION] = clock_out_function_q;
      drv_oe[pta_pkg::PIN_CLOCK_OUT_FUNCTION] = i_osc_cfg.rc_mode;
      drv_val[pta_pkg::PIN_OSC_IN] = 1'b0;
      drv_oe[pta_pkg::PIN_OSC_IN] = 1'b0;
    end
    else if (!pin6_port)
    begin
      drv_val[pta_pkg::PIN_CLOCK_OUT_FUNCTION] = clock_out_function_q;
      drv_oe[pta_pkg::PIN_CLOCK_OUT_FUNCTION] = 1'b1;
    end
  end

  assign o_pin = drv_val;
  assign o_pin_oe = drv_oe;
  // timer clock sees the pin only while it is an input
  assign o_timer_zero_ext_clock_in = sync2_q[pta_pkg::PIN_SRQ] & dir_q[pta_pkg::PIN_SRQ];

  // read mux; no read changes any state
  always_comb
  begin
    case (i_addr)
      pta_pkg::ADDR_LEVEL: rd_d = level_view;
      pta_pkg::ADDR_LATCH: rd_d = latch_q & own_mask;
      pta_pkg::ADDR_DIR: rd_d = dir_q & own_mask;
      pta_pkg::ADDR_ANSEL: rd_d = ansel_q;
      pta_pkg::ADDR_SLEW: rd_d = slew_q;
      pta_pkg::ADDR_STATUS: rd_d = {6'h00, pin6_port, ~osc_owns_hi};
      default: rd_d = 8'h00;
    endcase
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      rdata_q <= 8'h00;
    else if (i_rd)
      rdata_q <= rd_d;
    else
      rdata_q <= 8'h00;
  end

  assign o_rdata = rdata_q;
endmodule : pta_port
`default_nettype wire

// *** tb/pta_board.sv ***
// Purpose: board circuitry on the port pins
// Assumes: the bench sets the level that the board puts on undriven pins
// Notes: a driving port pin wins over the board
`default_nettype none
module pta_board (
  input wire logic [7:0] i_drv,
  input wire logic [7:0] i_pin,
  input wire logic [7:0] i_oe,
  output logic [7:0] o_wire
);
  timeunit 1ns;
  timeprecision 1ns;
  assign o_wire = (i_oe & i_pin) | (~i_oe & i_drv);
endmodule : pta_board
`default_nettype wire

// *** tb/pta_port_chk.sv ***
// Purpose: port-level assertions for the port block
// Assumes: one clock, synchronous reset
// Notes: pins 0 and 1 carry no shared output functions, so they show the plain port output path
`default_nettype none
module pta_port_chk #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic [pta_pkg::ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire pta_pkg::pta_osc_cfg_t i_osc_cfg,
  input wire pta_pkg::pta_periph_t i_periph,
  input wire logic [WIDTH-1:0] i_pin,
  input wire logic [WIDTH-1:0] o_pin,
  input wire logic [WIDTH-1:0] o_pin_oe
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  property p_idle; !i_rd |=> o_rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
  property p_dir; i_wr && i_addr == pta_pkg::ADDR_DIR |=> o_pin_oe[1:0] == ~$past(i_wdata[1:0]); endproperty
  a_dir: assert property (p_dir) else $error("driver enable wrong");
  property p_lat; i_wr && i_addr == pta_pkg::ADDR_LATCH |=> o_pin[1:0] == $past(i_wdata[1:0]); endproperty
  a_lat: assert property (p_lat) else $error("latch not on pins");
  property p_dac; i_periph.dac_en |-> !o_pin_oe[2]; endproperty
  a_dac: assert property (p_dac) else $error("pin 2 driven under dac");
  property p_srq; i_periph.srq_en |-> o_pin_oe[4] && o_pin[4] == i_periph.srq_val; endproperty
  a_srq: assert property (p_srq) else $error("pin 4 not latch output");
  property p_osc; !i_osc_cfg.int_osc && i_rd && i_addr == pta_pkg::ADDR_DIR |=> o_rdata[7:6] == 2'h0; endproperty
  a_osc: assert property (p_osc) else $error("oscillator pins not zero");
  property p_sync;
    ($stable(i_pin[4]) [*3]) ##0 (i_rd && i_addr == pta_pkg::ADDR_LEVEL) |=> o_rdata[4] == $past(i_pin[4]);
  endproperty
  a_sync: assert property (p_sync) else $error("pin level read wrong");
  property p_rc; i_osc_cfg.rc_mode && !i_osc_cfg.int_osc |-> o_pin_oe[6]; endproperty
  a_rc: assert property (p_rc) else $error("clock out not driven");
endmodule : pta_port_chk
bind pta_port pta_port_chk #(.WIDTH(WIDTH)) i_chk (.i_ref_clk, .i_srst, .i_addr, .i_wdata, .i_wr, .i_rd,
  .o_rdata, .i_osc_cfg, .i_periph, .i_pin, .o_pin, .o_pin_oe);
`default_nettype wire

// *** tb/pta_port_test.sv ***
// Purpose: self-checking bench for the port block
// Assumes: board puts 5A on undriven pins
// Notes: rows wait three cycles so pin changes pass the synchroniser
`default_nettype none
module pta_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [3:0] wa; logic [7:0] wd; logic [3:0] ra; logic [7:0] ex;} pta_row_t;
  logic clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, osc_clk = 1'b0, last, tmr;
  logic [7:0] slim;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, drv = 8'h5A, rdata, pin, opin, oe, got;
  pta_pkg::pta_osc_cfg_t cfg = 3'h4;
  pta_pkg::pta_periph_t per = 9'h000;
  int fail_count = 0, samples_checked = 0, n = 0;
  logic [3:0] rst_a [5] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h0};
  logic [7:0] rst_e [5] = '{8'h00, 8'hFF, 8'h2F, 8'h01, 8'h50};
  pta_row_t rows [7] = '{'{4'h2, 8'h0F, 4'h2, 8'h0F}, '{4'h1, 8'hA5, 4'h1, 8'hA5}, '{4'h0, 8'h3C, 4'h1, 8'h3C},
    '{4'h3, 8'hFF, 4'h3, 8'h2F}, '{4'h4, 8'hFF, 4'h4, 8'h01}, '{4'h3, 8'h00, 4'h0, 8'h3A}, '{4'hF, 8'hFF, 4'hF, 8'h00}};
  always #12.5 clk = ~clk;
  pta_port i_pta_port (.i_ref_clk(clk), .i_srst(srst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_osc_cfg(cfg), .i_periph(per), .i_osc_in_clk(osc_clk), .i_pin(pin), .o_pin(opin),
    .o_pin_oe(oe), .o_timer_zero_ext_clock_in(tmr), .o_slew_limit(slim));
  pta_board i_pta_board (.i_drv(drv), .i_pin(opin), .i_oe(oe), .o_wire(pin));
  task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] gt);
    samples_checked++;
    if (gt !== ex)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, ex, gt);
    end
  endtask : chk
  task automatic wrt(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wrt
  task automatic rdr(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    got = rdata;
  endtask : rdr
  task automatic results;
    $display("checks %0d errors %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results
  // generous: the sequence needs about 110 cycles
  initial
  begin
    #100us;
    fail_count++;
    results();
  end
  initial
  begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    foreach (rst_a[k])
    begin
      rdr(rst_a[k]);
      chk("reset", rst_e[k], got);
    end
    chk("slew limit", 8'hFF, slim);
    chk("timer clock in", 8'h01, {7'h00, tmr});
    foreach (rows[k])
    begin
      wrt(rows[k].wa, rows[k].wd);
      repeat (3) @(posedge clk);
      rdr(rows[k].ra);
      chk("row", rows[k].ex, got);
    end
    chk("timer clock out pin", 8'h00, {7'h00, tmr});
    @(posedge clk);
    cfg <= 3'h0;
    wrt(pta_pkg::ADDR_DIR, 8'hFF);
    rdr(pta_pkg::ADDR_DIR);
    chk("osc dir", 8'h3F, got);
    wrt(pta_pkg::ADDR_DIR, 8'h00);
    per <= 9'h1C0;
    @(negedge clk);
    chk("periph oe", 8'h10, oe & 8'h14);
    chk("srq", 8'h10, opin & 8'h10);
    @(posedge clk);
    per <= 9'h000;
    cfg <= 3'h1;
    repeat (4) @(posedge clk);
    last = opin[6];
    for (int k = 0; k < 36; k++)
    begin
      @(posedge clk);
      if (k < 32)
        osc_clk <= ~osc_clk;
      @(negedge clk);
      if (opin[6] !== last)
        n++;
      last = opin[6];
    end
    chk("clock out", 8'h08, n[7:0]);
    results();
  end
endmodule : pta_port_test
`default_nettype wire
